// ---- rtl/ptl_pkg.sv ----
// Purpose: shared constants and types for the power and thermal limit block
// Assumes: 125 MHz core clock, power in 16-bit units, temperatures in whole degrees C
// Notes: averaging time parameters are given as power-of-two shift amounts

package ptl_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PWR_W = 16;
	localparam int AVG_W = 24;
	localparam int TEMP_W = 8;
	localparam int NUM_SENSORS = 4;
	localparam int FRAC_W = 8;

	// ----------------------------------------------------------------
	// thermal target register
	// ----------------------------------------------------------------
	localparam logic [31:0] THERM_TARGET_ADDR = 32'h0000_01a2;
	localparam int OFS_LSB = 24;
	localparam int OFS_MSB = 29;
	localparam int TJMAX_LSB = 16;
	localparam int TJMAX_MSB = 23;
	localparam int TAU_LSB = 0;
	localparam int TAU_MSB = 6;
	localparam logic [5:0] OFS_RESET = 6'h00;
	localparam logic [6:0] TAU_RESET = 7'h00;
	localparam logic [3:0] MAX_SHIFT = 4'hf;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int MOD_PERIOD_NS = 32000;
	localparam int MOD_PERIOD_CYC = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MOD_ON_PCT = 25;
	localparam int MOD_ON_CYC = (MOD_PERIOD_CYC * MOD_ON_PCT) / 100;
	localparam int HYST_TIME_NS = 1000;
	localparam int HYST_CYC = (HYST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// guard band for preemptive cap limiting, in power units
	localparam logic [PWR_W-1:0] CAP_GUARD = 16'h0040;
	localparam logic [AVG_W-1:0] LIMIT_EFF_RESET = 24'hffffff;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PWR_W-1:0] sustained;
		logic [PWR_W-1:0] burst;
		logic [PWR_W-1:0] duty;
		logic [PWR_W-1:0] cap;
		logic [3:0] tau;
		logic duty_en;
		logic cap_en;
	} pkg_limits_t;

	typedef struct packed {
		logic en;
		logic [PWR_W-1:0] sustained;
		logic [PWR_W-1:0] burst;
		logic [PWR_W-1:0] duty;
		logic [3:0] tau;
	} plat_limits_t;

	typedef struct packed {
		logic sustained;
		logic burst;
		logic duty;
		logic cap;
		logic plat_sustained;
		logic plat_burst;
		logic plat_duty;
	} throttle_t;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_DN_PENDING,
		OP_UP_PENDING
	} op_state_t;

endpackage

// ---- rtl/power_thermal_limit_control.sv ----
// Purpose: package and platform power limiting plus thermal control circuit
// Assumes: sensor readings are degrees below maximum temperature, 0 means at maximum
// Notes: power and sensor buses are slow-moving and pass a two-flop synchroniser
//
// Behaviour
// R1 - package power average tracked by EWMA with its own time constant against sustained limit
// R2 - package power above burst limit raises fast limiting
// R3 - package power above spike duty limit reactively lowers frequency
// R4 - absolute cap limited preemptively with a guard band below the cap
// R5 - spike duty limit and absolute cap disabled after reset until configured
// R6 - platform sustained limit uses EWMA of platform power, own constant
// R7 - platform burst gives fast limiting, platform duty gives reactive frequency limit
// R8 - platform input, limits and constant ignored unless enabled
// R9 - platform power supplied excludes battery charging power
// R10 - separate averaging constants for package and platform limits
// R11 - effective sustained limits slew toward new values at new time constant
// R12 - thermal control circuit activates when any sensor reaches maximum temperature
// R13 - while active, core and graphics throttling held until deactivation
// R14 - factory maximum temperature read in bits 23:16, not writable
// R15 - thermal protection always on, no disable bit
// R16 - setpoint is maximum temperature minus offset in bits 29:24
// R17 - zero time window compares instantaneous temperature with setpoint
// R18 - nonzero window in bits 6:0 compares temperature EWMA with setpoint
// R19 - averaged mode regulates by frequency only, short overshoot allowed
// R20 - software keeps nonzero offset below other passive trip points
// R21 - core power reduced by frequency/voltage and by clock gating duty cycle
// R22 - activation at maximum temperature regardless of offset
// R23 - clock gating 25% on, 75% off, 32 us period when frequency is at minimum
// R24 - voltage before frequency going up, frequency before voltage going down
// R25 - setpoint clamps at zero when offset exceeds maximum temperature

`timescale 1ns/1ps
`default_nettype none

module power_thermal_limit_control
	import ptl_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic [PWR_W-1:0] I_PKG_POWER,
	input wire logic [PWR_W-1:0] I_PLAT_POWER,
	input wire logic [NUM_SENSORS*TEMP_W-1:0] I_SENSOR_REL,
	input wire logic [TEMP_W-1:0] I_TJMAX_FUSE,
	input wire pkg_limits_t I_PKG_LIMITS,
	input wire plat_limits_t I_PLAT_LIMITS,
	input wire logic I_FREQ_AT_MIN,
	input wire logic [31:0] I_MSR_ADDR,
	input wire logic I_MSR_WE,
	input wire logic I_MSR_RE,
	input wire logic [31:0] I_MSR_WDATA,
	output logic [31:0] O_MSR_RDATA,
	output logic O_MSR_ACK,
	output logic O_MSR_ERR,
	output throttle_t O_THROTTLE,
	output logic O_THERMAL_CONTROL_CIRCUIT_ACTIVE,
	output logic O_CORE_THROTTLE,
	output logic O_GFX_THROTTLE,
	output logic O_AVG_TEMP_THROTTLE,
	output logic O_CLK_RUN,
	output logic O_FREQ_DOWN,
	output logic O_VOLT_DOWN,
	output logic O_FREQ_UP,
	output logic O_VOLT_UP
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PWR_W-1:0] pkg_pwr_s1;
		logic [PWR_W-1:0] pkg_pwr_s2;
		logic [PWR_W-1:0] plat_pwr_s1;
		logic [PWR_W-1:0] plat_pwr_s2;
		logic [NUM_SENSORS*TEMP_W-1:0] sens_s1;
		logic [NUM_SENSORS*TEMP_W-1:0] sens_s2;
		logic [TEMP_W-1:0] fuse_s1;
		logic [TEMP_W-1:0] fuse_s2;
		logic [1:0] fuse_wait;
		logic fuse_done;
		logic [TEMP_W-1:0] tjmax;
		logic [5:0] offset;
		logic [6:0] temp_tau;
		logic [AVG_W-1:0] pkg_avg;
		logic [AVG_W-1:0] plat_avg;
		logic [AVG_W-1:0] sust_eff;
		logic [AVG_W-1:0] plat_sust_eff;
		logic [AVG_W-1:0] temp_avg;
		throttle_t throttle;
		logic circuit_active;
		logic avg_throttle;
		logic [7:0] hyst_cnt;
		logic [11:0] mod_cnt;
		logic clk_run;
		op_state_t op;
		logic throttled;
		logic freq_dn;
		logic volt_dn;
		logic freq_up;
		logic volt_up;
		logic [31:0] msr_rdata;
		logic msr_ack;
		logic msr_err;
	} state_t;

	localparam logic [7:0] HYST_LOAD = 8'(HYST_CYC);
	localparam logic [11:0] MOD_LAST = 12'(MOD_PERIOD_CYC - 1);
	localparam logic [11:0] MOD_ON = 12'(MOD_ON_CYC);

	state_t s_reg;
	state_t s_next;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one EWMA step; a shift of zero follows the input directly
	// limitation: rising toward a target, the average settles up to 2^shift-1 lsbs short
	function automatic logic [AVG_W-1:0] ewma(input logic [AVG_W-1:0] avg, input logic [AVG_W-1:0] x,
		input logic [3:0] sh);
		logic signed [AVG_W:0] d;
		d = $signed({1'b0, x}) - $signed({1'b0, avg});
		ewma = avg + AVG_W'(d >>> sh);
	endfunction

	function automatic logic [AVG_W-1:0] to_fix(input logic [PWR_W-1:0] v);
		to_fix = {v, 8'h00};
	endfunction

	function automatic logic [3:0] sat_shift(input logic [6:0] t);
		sat_shift = (t > 7'(MAX_SHIFT)) ? MAX_SHIFT : t[3:0];
	endfunction

	// ----------------------------------------------------------------
	// combinational view
	// ----------------------------------------------------------------
	logic [TEMP_W-1:0] min_rel;
	logic [TEMP_W-1:0] abs_inst;
	logic [TEMP_W-1:0] setpoint;
	logic max_hit;
	logic offset_hit;
	logic avg_hit;
	logic any_req;
	logic reg_hit;
	logic [PWR_W:0] cap_probe;

	always_comb begin
		min_rel = s_reg.sens_s2[TEMP_W-1:0];
		for (int i = 1; i < NUM_SENSORS; i++) begin
			if (s_reg.sens_s2[i*TEMP_W +: TEMP_W] < min_rel) begin
				min_rel = s_reg.sens_s2[i*TEMP_W +: TEMP_W];
			end
		end
		abs_inst = (min_rel > s_reg.tjmax) ? 8'h00 : s_reg.tjmax - min_rel;
		// setpoint never wraps below zero
		setpoint = ({2'b00, s_reg.offset} > s_reg.tjmax) ? 8'h00 : s_reg.tjmax - {2'b00, s_reg.offset}; // R16 R25
		// the hottest sensor at maximum triggers whatever the offset, once the factory maximum is caught
		max_hit = s_reg.fuse_done && (min_rel == 8'h00); // R12 R22
		offset_hit = s_reg.fuse_done && (s_reg.temp_tau == 7'h00) && (abs_inst >= setpoint); // R17
		avg_hit = s_reg.fuse_done && (s_reg.temp_tau != 7'h00) && (s_reg.temp_avg[15:8] >= setpoint); // R18
		// one bit wider so the guard cannot wrap near full scale
		cap_probe = {1'b0, s_reg.pkg_pwr_s2} + {1'b0, CAP_GUARD};
		reg_hit = (I_MSR_ADDR == THERM_TARGET_ADDR);
		any_req = (|s_reg.throttle) || s_reg.circuit_active || s_reg.avg_throttle;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;

		// synchronisers
		s_next.pkg_pwr_s1 = I_PKG_POWER;
		s_next.pkg_pwr_s2 = s_reg.pkg_pwr_s1;
		s_next.plat_pwr_s1 = I_PLAT_POWER; // R9
		s_next.plat_pwr_s2 = s_reg.plat_pwr_s1;
		s_next.sens_s1 = I_SENSOR_REL;
		s_next.sens_s2 = s_reg.sens_s1;
		s_next.fuse_s1 = I_TJMAX_FUSE;
		s_next.fuse_s2 = s_reg.fuse_s1;

		// factory maximum caught once, after the synchroniser has filled
		// triggers wait for it: a zero maximum would trip the circuit at once
		if (!s_reg.fuse_done) begin
			if (s_reg.fuse_wait == 2'h2) begin
				s_next.tjmax = s_reg.fuse_s2; // R14
				s_next.fuse_done = 1'b1;
			end else begin
				s_next.fuse_wait = s_reg.fuse_wait + 2'h1;
			end
		end

		// ----------------------------------------------------------------
		// package power limits
		// ----------------------------------------------------------------
		s_next.pkg_avg = ewma(s_reg.pkg_avg, to_fix(s_reg.pkg_pwr_s2), I_PKG_LIMITS.tau); // R1 R10
		// limit changes settle at the rate of the current time constant
		s_next.sust_eff = ewma(s_reg.sust_eff, to_fix(I_PKG_LIMITS.sustained), I_PKG_LIMITS.tau); // R11
		s_next.throttle.sustained = (s_reg.pkg_avg > s_reg.sust_eff); // R1
		s_next.throttle.burst = (s_reg.pkg_pwr_s2 > I_PKG_LIMITS.burst); // R2
		s_next.throttle.duty = I_PKG_LIMITS.duty_en && (s_reg.pkg_pwr_s2 > I_PKG_LIMITS.duty); // R3 R5
		// acts ahead of the cap so a spike never reaches it
		s_next.throttle.cap = I_PKG_LIMITS.cap_en && (cap_probe >= {1'b0, I_PKG_LIMITS.cap}); // R4 R5

		// ----------------------------------------------------------------
		// platform power limits
		// ----------------------------------------------------------------
		if (I_PLAT_LIMITS.en) begin
			s_next.plat_avg = ewma(s_reg.plat_avg, to_fix(s_reg.plat_pwr_s2), I_PLAT_LIMITS.tau); // R6 R10
			s_next.plat_sust_eff = ewma(s_reg.plat_sust_eff, to_fix(I_PLAT_LIMITS.sustained),
				I_PLAT_LIMITS.tau); // R11
			s_next.throttle.plat_sustained = (s_reg.plat_avg > s_reg.plat_sust_eff); // R6
			s_next.throttle.plat_burst = (s_reg.plat_pwr_s2 > I_PLAT_LIMITS.burst); // R7
			s_next.throttle.plat_duty = (s_reg.plat_pwr_s2 > I_PLAT_LIMITS.duty); // R7
		end else begin
			// disabled: averages parked so enabling starts clean
			s_next.plat_avg = '0; // R8
			s_next.plat_sust_eff = LIMIT_EFF_RESET;
			s_next.throttle.plat_sustained = 1'b0;
			s_next.throttle.plat_burst = 1'b0;
			s_next.throttle.plat_duty = 1'b0;
		end

		// ----------------------------------------------------------------
		// thermal control circuit
		// ----------------------------------------------------------------
		s_next.temp_avg = ewma(s_reg.temp_avg, {8'h00, abs_inst, 8'h00}, sat_shift(s_reg.temp_tau)); // R18
		// the averaged trigger steers frequency only and never gates clocks
		s_next.avg_throttle = avg_hit; // R19
		// no enable term: protection cannot be switched off
		if (max_hit || offset_hit) begin // R15
			s_next.circuit_active = 1'b1; // R12
			s_next.hyst_cnt = HYST_LOAD;
		end else if (s_reg.circuit_active) begin
			// hold until cool and the hysteresis timer has run out
			// keeps a sensor hovering at the trip point from chattering the throttle
			if (s_reg.hyst_cnt == 8'h00) begin
				s_next.circuit_active = 1'b0; // R13
			end else begin
				s_next.hyst_cnt = s_reg.hyst_cnt - 8'h01;
			end
		end

		// clock modulation as the second means once frequency is exhausted
		// frequency floor is reported from outside; gating never starts while steps remain
		if (s_reg.circuit_active && I_FREQ_AT_MIN) begin // R21
			s_next.mod_cnt = (s_reg.mod_cnt == MOD_LAST) ? 12'h000 : s_reg.mod_cnt + 12'h001; // R23
			s_next.clk_run = (s_next.mod_cnt < MOD_ON); // R23
		end else begin
			s_next.mod_cnt = 12'h000;
			s_next.clk_run = 1'b1;
		end

		// ----------------------------------------------------------------
		// operating point sequencing
		// ----------------------------------------------------------------
		s_next.freq_dn = 1'b0;
		s_next.volt_dn = 1'b0;
		s_next.freq_up = 1'b0;
		s_next.volt_up = 1'b0;
		case (s_reg.op)
			OP_IDLE: begin
				if (any_req && !s_reg.throttled) begin
					s_next.freq_dn = 1'b1; // R24
					s_next.op = OP_DN_PENDING;
				end else if (!any_req && s_reg.throttled) begin
					s_next.volt_up = 1'b1; // R24
					s_next.op = OP_UP_PENDING;
				end
			end
			OP_DN_PENDING: begin
				s_next.volt_dn = 1'b1; // R24
				s_next.throttled = 1'b1;
				s_next.op = OP_IDLE;
			end
			OP_UP_PENDING: begin
				s_next.freq_up = 1'b1; // R24
				s_next.throttled = 1'b0;
				s_next.op = OP_IDLE;
			end
			default: begin
				s_next.op = OP_IDLE;
			end
		endcase

		// ----------------------------------------------------------------
		// register port
		// ----------------------------------------------------------------
		// unmapped requests still answer so software never waits on a missing reply
		s_next.msr_ack = I_MSR_WE || I_MSR_RE;
		s_next.msr_err = (I_MSR_WE || I_MSR_RE) && !reg_hit;
		s_next.msr_rdata = 32'h0000_0000;
		if (I_MSR_WE && reg_hit) begin
			// maximum temperature field is read-only
			s_next.offset = I_MSR_WDATA[OFS_MSB:OFS_LSB]; // R14 R16
			s_next.temp_tau = I_MSR_WDATA[TAU_MSB:TAU_LSB]; // R18
		end
		if (I_MSR_RE && reg_hit) begin
			s_next.msr_rdata[OFS_MSB:OFS_LSB] = s_reg.offset;
			s_next.msr_rdata[TJMAX_MSB:TJMAX_LSB] = s_reg.tjmax; // R14
			s_next.msr_rdata[TAU_MSB:TAU_LSB] = s_reg.temp_tau;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			s_reg <= '0;
			// sensors start cold so nothing trips before real readings arrive
			s_reg.sens_s1 <= '1;
			s_reg.sens_s2 <= '1;
			s_reg.offset <= OFS_RESET;
			s_reg.temp_tau <= TAU_RESET;
			s_reg.sust_eff <= LIMIT_EFF_RESET;
			s_reg.plat_sust_eff <= LIMIT_EFF_RESET;
			s_reg.clk_run <= 1'b1;
			s_reg.op <= OP_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign O_MSR_RDATA = s_reg.msr_rdata;
	assign O_MSR_ACK = s_reg.msr_ack;
	assign O_MSR_ERR = s_reg.msr_err;
	assign O_THROTTLE = s_reg.throttle;
	assign O_THERMAL_CONTROL_CIRCUIT_ACTIVE = s_reg.circuit_active;
	// both domains follow the same flop
	assign O_CORE_THROTTLE = s_reg.circuit_active; // R13
	assign O_GFX_THROTTLE = s_reg.circuit_active; // R13
	assign O_AVG_TEMP_THROTTLE = s_reg.avg_throttle;
	assign O_CLK_RUN = s_reg.clk_run;
	assign O_FREQ_DOWN = s_reg.freq_dn;
	assign O_VOLT_DOWN = s_reg.volt_dn;
	assign O_FREQ_UP = s_reg.freq_up;
	assign O_VOLT_UP = s_reg.volt_up;

endmodule

`default_nettype wire

// ---- verif/ptl_sensor_model.sv ----
// Purpose: far-side model of the temperature sensors and the platform supply
// Assumes: one hot sensor, the others fixed at 8'h30 below maximum
// Notes: readings are degrees below maximum, refreshed every clock
`timescale 1ns/1ps
`default_nettype none

module ptl_sensor_model
	import ptl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_hot_idx,
	input wire logic [TEMP_W-1:0] i_hot_rel,
	input wire logic [PWR_W-1:0] i_sys_power,
	input wire logic [PWR_W-1:0] i_charge_power,
	output logic [NUM_SENSORS*TEMP_W-1:0] o_sensor_rel,
	output logic [PWR_W-1:0] o_plat_power
);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sensor_rel <= '1;
			o_plat_power <= '0;
		end else begin
			for (int i = 0; i < NUM_SENSORS; i++)
				o_sensor_rel[i*TEMP_W +: TEMP_W] <= (2'(i) == i_hot_idx) ? i_hot_rel : 8'h30;
			// charger draw removed so the block never limits on it
			o_plat_power <= (i_sys_power > i_charge_power) ? i_sys_power - i_charge_power : '0;
		end
	end
endmodule

`default_nettype wire

// ---- verif/power_thermal_limit_control_assertions.sv ----
// Purpose: port-level checks of power and thermal limiting
// Assumes: stimulus holds levels for several cycles
// Notes: waits of several samples cover the input synchroniser
`timescale 1ns/1ps
`default_nettype none

module ptl_checker
	import ptl_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic [PWR_W-1:0] I_PKG_POWER,
	input wire logic [NUM_SENSORS*TEMP_W-1:0] I_SENSOR_REL,
	input wire pkg_limits_t I_PKG_LIMITS,
	input wire logic I_FREQ_AT_MIN,
	input wire logic [31:0] I_MSR_ADDR,
	input wire logic I_MSR_WE,
	input wire logic I_MSR_RE,
	input wire logic [31:0] O_MSR_RDATA,
	input wire logic O_MSR_ACK,
	input wire logic O_MSR_ERR,
	input wire throttle_t O_THROTTLE,
	input wire logic O_THERMAL_CONTROL_CIRCUIT_ACTIVE,
	input wire logic O_CORE_THROTTLE,
	input wire logic O_GFX_THROTTLE,
	input wire logic O_CLK_RUN,
	input wire logic O_FREQ_DOWN,
	input wire logic O_VOLT_DOWN,
	input wire logic O_FREQ_UP,
	input wire logic O_VOLT_UP
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	// ----
	// helpers
	// ----
	logic any_zero;
	logic [11:0] off_cnt;
	always_comb begin
		any_zero = 1'b0;
		for (int i = 0; i < NUM_SENSORS; i++)
			if (I_SENSOR_REL[i*TEMP_W +: TEMP_W] == 8'h00)
				any_zero = 1'b1;
	end
	// too long for a repetition, so the gated span is counted
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			off_cnt <= 12'h000;
		else
			off_cnt <= O_CLK_RUN ? 12'h000 : off_cnt + 12'h001;
	end

	// ----
	// checks
	// ----
	a_msr_ack: assert property ((I_MSR_WE || I_MSR_RE) |=> O_MSR_ACK)
		else $error("register request not acknowledged");
	a_msr_unmapped: assert property ((I_MSR_WE || I_MSR_RE) && I_MSR_ADDR != THERM_TARGET_ADDR
		|=> O_MSR_ERR && O_MSR_RDATA == '0)
		else $error("unmapped access without error");
	a_thermal_at_max: assert property (any_zero [*6] |=> O_THERMAL_CONTROL_CIRCUIT_ACTIVE)
		else $error("sensor at maximum without thermal control");
	a_thermal_domains: assert property (O_CORE_THROTTLE == O_THERMAL_CONTROL_CIRCUIT_ACTIVE
		&& O_GFX_THROTTLE == O_THERMAL_CONTROL_CIRCUIT_ACTIVE)
		else $error("core and graphics throttle differ from thermal control");
	a_gate_span: assert property ($rose(O_CLK_RUN) && O_THERMAL_CONTROL_CIRCUIT_ACTIVE && I_FREQ_AT_MIN
		|-> off_cnt == 12'(MOD_PERIOD_CYC - MOD_ON_CYC))
		else $error("gated span length wrong");
	a_burst_flag: assert property ((I_PKG_POWER > I_PKG_LIMITS.burst) [*4] |=> O_THROTTLE.burst)
		else $error("burst limit not applied");
	a_duty_off: assert property (!I_PKG_LIMITS.duty_en [*2] |=> !O_THROTTLE.duty)
		else $error("duty limit active while disabled");
	a_step_down: assert property ($rose(O_FREQ_DOWN) |=> O_VOLT_DOWN && !O_FREQ_DOWN)
		else $error("voltage step did not follow frequency step");
	a_step_up: assert property ($rose(O_VOLT_UP) |=> O_FREQ_UP && !O_VOLT_UP)
		else $error("frequency step did not follow voltage step");
endmodule

bind power_thermal_limit_control ptl_checker u_ptl_checker (.I_MCLK, .I_RST, .I_PKG_POWER, .I_SENSOR_REL,
	.I_PKG_LIMITS, .I_FREQ_AT_MIN, .I_MSR_ADDR, .I_MSR_WE, .I_MSR_RE, .O_MSR_RDATA, .O_MSR_ACK, .O_MSR_ERR,
	.O_THROTTLE, .O_THERMAL_CONTROL_CIRCUIT_ACTIVE, .O_CORE_THROTTLE, .O_GFX_THROTTLE, .O_CLK_RUN,
	.O_FREQ_DOWN, .O_VOLT_DOWN, .O_FREQ_UP, .O_VOLT_UP);

`default_nettype wire

// ---- verif/power_thermal_limit_control_tb_top.sv ----
// Purpose: directed bench for power and thermal limiting
// Assumes: fuse strap fixed at 32 degrees, limits driven as levels
// Notes: every check waits past the two-flop input synchroniser
`timescale 1ns/1ps
`default_nettype none

module power_thermal_limit_control_tb_top
	import ptl_pkg::*;
;
	localparam logic [7:0] FUSE = 8'h20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic at_min = 1'b0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [1:0] hot = 2'h2;
	logic [7:0] rel = 8'h30;
	logic [15:0] pwr = '0;
	logic [15:0] sys = '0;
	logic [15:0] chg = '0;
	logic [31:0] addr = '0;
	logic [31:0] wd = '0;
	pkg_limits_t lim = {16'hffff, 16'hffff, 16'hffff, 16'hffff, 4'h4, 2'b00};
	plat_limits_t pl = {1'b0, 16'hffff, 16'hffff, 16'hffff, 4'h3};
	logic [31:0] sens;
	logic [15:0] ppwr;
	logic [31:0] rd;
	logic ack, err, therm, core, gfx, avg, run;
	throttle_t thr;
	int failures = 0;
	int check_count = 0;
	int n;

	ptl_sensor_model u_ptl_sensor_model (.i_clk(clk), .i_rst(rst), .i_hot_idx(hot), .i_hot_rel(rel),
		.i_sys_power(sys), .i_charge_power(chg), .o_sensor_rel(sens), .o_plat_power(ppwr));
	power_thermal_limit_control u_power_thermal_limit_control (.I_MCLK(clk), .I_RST(rst), .I_PKG_POWER(pwr),
		.I_PLAT_POWER(ppwr), .I_SENSOR_REL(sens), .I_TJMAX_FUSE(FUSE), .I_PKG_LIMITS(lim),
		.I_PLAT_LIMITS(pl), .I_FREQ_AT_MIN(at_min), .I_MSR_ADDR(addr), .I_MSR_WE(we), .I_MSR_RE(re),
		.I_MSR_WDATA(wd), .O_MSR_RDATA(rd), .O_MSR_ACK(ack), .O_MSR_ERR(err), .O_THROTTLE(thr),
		.O_THERMAL_CONTROL_CIRCUIT_ACTIVE(therm), .O_CORE_THROTTLE(core), .O_GFX_THROTTLE(gfx),
		.O_AVG_TEMP_THROTTLE(avg),
		.O_CLK_RUN(run), .O_FREQ_DOWN(), .O_VOLT_DOWN(), .O_FREQ_UP(), .O_VOLT_UP());

	always #4 clk = ~clk;

	// ----
	// tasks
	// ----
	task automatic end_of_test();
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic msr(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= w;
		re <= ~w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
		re <= 1'b0;
		#1;
		chk("ack", {31'h0, ack}, 32'h1);
	endtask
	task automatic pw(input logic [15:0] p, input logic [6:0] e);
		@(posedge clk);
		pwr <= p;
		cyc(8);
		chk("throttle", {25'h0, thr}, {25'h0, e});
	endtask
	task automatic th(input logic [7:0] r, input int k, input logic [3:0] e);
		@(posedge clk);
		rel <= r;
		cyc(k);
		chk("thermal", {28'h0, therm, core, gfx, avg}, {28'h0, e});
	endtask

	// ----
	// sequence
	// ----
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		cyc(4);
		chk("run", {31'h0, run}, 32'h1);
		msr(1'b0, THERM_TARGET_ADDR, '0);
		chk("reg_rst", rd, {2'h0, OFS_RESET, FUSE, 9'h000, TAU_RESET});
		msr(1'b1, THERM_TARGET_ADDR, 32'hc5ff_ff80);
		msr(1'b0, THERM_TARGET_ADDR, '0);
		chk("reg_wr", rd, 32'h0520_0000);
		msr(1'b0, 32'h0000_01a3, '0);
		chk("err", {31'h0, err}, 32'h1);
		lim.burst <= 16'h0100;
		pw(16'h0200, 7'h20);
		pw(16'h0050, 7'h00);
		lim.burst <= 16'hffff;
		lim.duty <= 16'h0100;
		pw(16'h0180, 7'h00);
		lim.duty_en <= 1'b1;
		pw(16'h0180, 7'h10);
		lim.duty_en <= 1'b0;
		lim.cap <= 16'h0200;
		pw(16'h01c0, 7'h00);
		lim.cap_en <= 1'b1;
		pw(16'h01c0, 7'h08);
		pw(16'h01bf, 7'h00);
		lim.cap_en <= 1'b0;
		lim.sustained <= 16'h0400;
		pw(16'h0300, 7'h00);
		cyc(300);
		chk("sus_below", {31'h0, thr.sustained}, 32'h0);
		@(posedge clk);
		lim.sustained <= 16'h0100;
		cyc(2);
		chk("slew", {31'h0, thr.sustained}, 32'h0);
		cyc(300);
		chk("sus_above", {31'h0, thr.sustained}, 32'h1);
		@(posedge clk);
		lim.sustained <= 16'hffff;
		sys <= 16'h0500;
		chg <= 16'h0300;
		pl.burst <= 16'h0100;
		pw(16'h0000, 7'h00);
		pl.en <= 1'b1;
		pw(16'h0000, 7'h02);
		chg <= 16'h0480;
		pw(16'h0000, 7'h00);
		chg <= 16'h0300;
		pl.burst <= 16'hffff;
		pl.duty <= 16'h0100;
		pw(16'h0000, 7'h01);
		pl.duty <= 16'hffff;
		pl.sustained <= 16'h0100;
		cyc(400);
		chk("plat_sus", {31'h0, thr.plat_sustained}, 32'h1);
		pl.en <= 1'b0;
		pw(16'h0000, 7'h00);
		th(8'h06, 8, 4'h0);
		th(8'h05, 8, 4'he);
		th(8'h06, 60, 4'he);
		cyc(150);
		chk("thermal_off", {31'h0, therm}, 32'h0);
		msr(1'b1, THERM_TARGET_ADDR, 32'h0500_0002);
		th(8'h04, 100, 4'h1);
		th(8'h00, 8, 4'hf);
		@(posedge clk);
		at_min <= 1'b1;
		n = 0;
		while (run === 1'b1 && n < 4100) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (run === 1'b0 && n < 3100) begin
			cyc(1);
			n++;
		end
		chk("off_span", n, MOD_PERIOD_CYC - MOD_ON_CYC);
		@(posedge clk);
		at_min <= 1'b0;
		// offset larger than the strap must clamp, not wrap
		msr(1'b1, THERM_TARGET_ADDR, 32'h3f00_0000);
		th(8'h30, 300, 4'he);
		@(posedge clk);
		rst <= 1'b1;
		cyc(2);
		chk("in_reset", {30'h0, therm, run}, 32'h1);
		@(posedge clk);
		rst <= 1'b0;
		cyc(4);
		// register contents must come back from the second reset as well
		msr(1'b0, THERM_TARGET_ADDR, '0);
		chk("reg_rst2", rd, {2'h0, OFS_RESET, FUSE, 9'h000, TAU_RESET});
		th(8'h30, 8, 4'h0);
		end_of_test();
	end

	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_of_test();
	end
endmodule

`default_nettype wire
